// File: shared/cafo_pkg.sv
/*
 * cafo_pkg: register map, command codes, flag positions and datapath
 * constants for the compare / adjust / flag-ops execution block.
 * Assumes a 32-bit Avalon-MM slave port with byte addressing.
 */
package cafo_pkg;
  // ==========================================================
  // bus and register map
  localparam int unsigned ADDR_W       = 7;
  localparam int unsigned DATA_W       = 32;
  localparam logic [6:0]  OFS_CMD      = 7'h00;
  localparam logic [6:0]  OFS_FLAGS    = 7'h04;
  localparam logic [6:0]  OFS_ACC      = 7'h08;
  localparam logic [6:0]  OFS_EXT      = 7'h0c;
  localparam logic [6:0]  OFS_SRC_IDX  = 7'h10;
  localparam logic [6:0]  OFS_DST_IDX  = 7'h14;
  localparam logic [6:0]  OFS_OPD_DEST = 7'h18;
  localparam logic [6:0]  OFS_OPD_SRC  = 7'h1c;
  localparam logic [6:0]  OFS_STATUS   = 7'h20;
  localparam int unsigned MEM_SEL_BIT  = 6;
  localparam int unsigned MEM_AW       = 4;
  localparam int unsigned MEM_DEPTH    = 16;
  localparam logic [3:0]  IDX_ONE      = 4'h1;

  // ==========================================================
  // command register fields
  localparam int unsigned CMD_WORD_BIT = 4;
  localparam int unsigned CMD_REP_BIT  = 5;
  typedef enum logic [3:0] {
    OP_NOP       = 4'h0,
    OP_CLR_IE      = 4'h1,
    OP_TOG_CARRY   = 4'h2,
    OP_COMPARE     = 4'h3,
    OP_STR_COMPARE = 4'h4,
    OP_SIGN_EXT    = 4'h5,
    OP_DEC_ADJ_ADD = 4'h6,
    OP_DEC_ADJ_SUB = 4'h7,
    OP_SOFT_INT  = 4'h8
  } cafo_op_t;

  // ==========================================================
  // flag bit positions
  localparam int unsigned FL_CARRY = 0;
  localparam int unsigned FL_PAR   = 2;
  localparam int unsigned FL_AUX   = 4;
  localparam int unsigned FL_ZERO  = 6;
  localparam int unsigned FL_SIGN  = 7;
  localparam int unsigned FL_IE    = 9;
  localparam int unsigned FL_DIR   = 10;
  localparam int unsigned FL_OVF   = 11;
  localparam logic [15:0] FLAGS_RST = 16'h0000;

  // ==========================================================
  // datapath constants
  localparam logic [7:0]  BCD_NIB_MASK = 8'h0f;
  localparam logic [7:0]  BCD_NIB_MAX  = 8'h09;
  localparam logic [7:0]  BCD_LO_ADJ   = 8'h06;
  localparam logic [7:0]  BCD_BYTE_MAX = 8'h9f;
  localparam logic [7:0]  BCD_HI_ADJ   = 8'h60;
  localparam logic [15:0] SIGN_LIMIT   = 16'h8000;
  localparam logic [15:0] EXT_NEG      = 16'hffff;
  localparam logic [15:0] EXT_POS      = 16'h0000;
  localparam logic [15:0] STEP_BYTE    = 16'h0001;
  localparam logic [15:0] STEP_WORD    = 16'h0002;
endpackage

// File: shared/cafo_alu_if.sv
/*
 * cafo_alu_if: operands and resulting flags of the subtract-for-flags
 * unit. Assumes a purely combinational consumer.
 */
`timescale 1ns/1ps
interface cafo_alu_if;
  logic [15:0] a;
  logic [15:0] b;
  logic        word_op;
  logic        carry;
  logic        aux;
  logic        ovf;
  logic        sign;
  logic        zero;
  logic        par;
  modport calc (input a, b, word_op, output carry, aux, ovf, sign, zero, par);
  modport user (output a, b, word_op, input carry, aux, ovf, sign, zero, par);
endinterface

// File: hdl/cafo_sub_flags.sv
/*
 * cafo_sub_flags: computes a - b for byte or word operands and returns
 * only the arithmetic flags; the difference itself is discarded.
 * Assumes the caller registers the flags.
 */
`timescale 1ns/1ps
module cafo_sub_flags
  import cafo_pkg::*;
(
  cafo_alu_if.calc calc
);
  logic [16:0] diff_w;
  logic [8:0]  diff_b;
  logic [15:0] res;

  // ==========================================================
  // subtract, borrow shows in the extra bit
  always_comb
  begin
    diff_w = {1'b0, calc.a} - {1'b0, calc.b};
    diff_b = {1'b0, calc.a[7:0]} - {1'b0, calc.b[7:0]};
    res    = calc.word_op ? diff_w[15:0] : {8'h00, diff_b[7:0]};
    calc.aux = calc.a[4] ^ calc.b[4] ^ res[4];
    calc.par = ~^res[7:0];
    if (calc.word_op)
    begin
      calc.carry = diff_w[16];
      calc.sign  = res[15];
      calc.zero  = (res == 16'h0000);
      calc.ovf   = (calc.a[15] ^ calc.b[15]) & (calc.a[15] ^ res[15]);
    end
    else
    begin
      calc.carry = diff_b[8];
      calc.sign  = res[7];
      calc.zero  = (res[7:0] == 8'h00);
      calc.ovf   = (calc.a[7] ^ calc.b[7]) & (calc.a[7] ^ res[7]);
    end
  end
endmodule

// File: hdl/cafo_exec.sv
/*
 * cafo_exec: execution datapath for flag ops, compare, string compare,
 * word sign extend and packed decimal adjust, with interrupt masking.
 * Assumes an Avalon-MM master on ref_clk and asynchronous interrupt pins.
 */
// Local design decisions: register access over Avalon-MM and the register addresses.
// Contract
// - clear-interrupt-enable zeroes the enable flag, all other flags kept.
// - maskable request line is ignored while interrupt enable is zero.
// - non-maskable and software interrupts are served even when disabled.
// - toggle-carry inverts carry and touches no other flag.
// - compare subtracts source from destination, keeps operands, updates flags.
// - compare flags describe destination relative to source.
// - string compare tests target element against source element, memory untouched.
// - both indexes step up when direction is zero, else down.
// - string compare accepted as single and repeat-prefixed form.
// - word sign extend fills extension from accumulator sign, flags kept.
// - add adjust adds 6 and sets aux carry on nibble above 9.
// - add adjust then adds 60H and sets carry on byte above 9FH.
// - sub adjust subtracts 6 and sets aux carry on nibble above 9.
// - sub adjust then subtracts 60H and sets carry on byte above 9FH.
`timescale 1ns/1ps
module cafo_exec
  import cafo_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [DATA_W-1:0] avs_writedata,
  output logic      [DATA_W-1:0] avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              maskable_request_line,
  input  wire logic              nmi_line,
  output logic                   maskable_taken,
  output logic                   nmi_taken,
  output logic                   soft_taken
);
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_ACK = 2'b10} cafo_bus_st_t;

  cafo_bus_st_t      state_q, state_d;
  logic              wait_q, wait_d;
  logic [31:0]       rdata_q, rdata_d, rd_val;
  logic [15:0]       flags_q, flags_d;
  logic [15:0]       acc_q, acc_d;
  logic [15:0]       ext_q, ext_d;
  logic [15:0]       src_idx_q, src_idx_d;
  logic [15:0]       dst_idx_q, dst_idx_d;
  logic [15:0]       opd_dest_q, opd_dest_d;
  logic [15:0]       opd_src_q, opd_src_d;
  logic              rep_q, rep_d;
  cafo_op_t          last_op_q, last_op_d;
  logic [7:0]        mem_q [MEM_DEPTH];
  logic [7:0]        mem_d [MEM_DEPTH];
  logic              soft_q, soft_d;
  logic              irq_s1_q, irq_s2_q, nmi_s1_q, nmi_s2_q, nmi_s3_q;
  logic              mask_take_q, mask_take_d, nmi_take_q, nmi_take_d;
  logic              fire_wr, cmd_fire, cmd_word, cmd_rep;
  cafo_op_t          cmd_op;
  logic [15:0]       step, str_dst, str_src;
  logic [7:0]        adj1, adj2;
  logic              aux1, cry1, da_sub;
  logic [MEM_AW-1:0] dst_lo, src_lo;

  cafo_alu_if alu ();

  cafo_sub_flags u_sub (
    .calc (alu.calc)
  );

  assign avs_waitrequest = wait_q;
  assign avs_readdata    = rdata_q;
  assign maskable_taken  = mask_take_q;
  assign nmi_taken       = nmi_take_q;
  assign soft_taken      = soft_q;

  // ==========================================================
  // command decode and operand selection
  assign fire_wr  = (state_q == ST_ACK) && avs_write;
  assign cmd_fire = fire_wr && (avs_address == OFS_CMD);
  assign cmd_op   = cafo_op_t'(avs_writedata[3:0]);
  assign cmd_word = avs_writedata[CMD_WORD_BIT];
  assign cmd_rep  = avs_writedata[CMD_REP_BIT];
  assign dst_lo   = dst_idx_q[MEM_AW-1:0];
  assign src_lo   = src_idx_q[MEM_AW-1:0];
  assign str_dst  = {mem_q[dst_lo + IDX_ONE], mem_q[dst_lo]};
  assign str_src  = {mem_q[src_lo + IDX_ONE], mem_q[src_lo]};
  assign step     = cmd_word ? STEP_WORD : STEP_BYTE;

  always_comb
  begin
    // destination minus source in both compare forms
    alu.word_op = cmd_word;
    alu.a       = (cmd_op == OP_STR_COMPARE) ? str_dst : opd_dest_q;
    alu.b       = (cmd_op == OP_STR_COMPARE) ? str_src : opd_src_q;
  end

  // ==========================================================
  // decimal adjust; second test sees the byte after the first step
  always_comb
  begin
    da_sub = (cmd_op == OP_DEC_ADJ_SUB);
    adj1   = acc_q[7:0];
    aux1   = flags_q[FL_AUX];
    if (((acc_q[7:0] & BCD_NIB_MASK) > BCD_NIB_MAX) || flags_q[FL_AUX])
    begin
      adj1 = da_sub ? acc_q[7:0] - BCD_LO_ADJ : acc_q[7:0] + BCD_LO_ADJ;
      aux1 = 1'b1;
    end
    adj2 = adj1;
    cry1 = flags_q[FL_CARRY];
    if ((adj1 > BCD_BYTE_MAX) || flags_q[FL_CARRY])
    begin
      adj2 = da_sub ? adj1 - BCD_HI_ADJ : adj1 + BCD_HI_ADJ;
      cry1 = 1'b1;
    end
  end

  // ==========================================================
  // register read mux; memory window answers on its own bit
  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (avs_address[MEM_SEL_BIT])
      rd_val = {24'h000000, mem_q[avs_address[MEM_AW+1:2]]};
    else
    begin
      unique case (avs_address)
        OFS_FLAGS:    rd_val = {16'h0000, flags_q};
        OFS_ACC:      rd_val = {16'h0000, acc_q};
        OFS_EXT:      rd_val = {16'h0000, ext_q};
        OFS_SRC_IDX:  rd_val = {16'h0000, src_idx_q};
        OFS_DST_IDX:  rd_val = {16'h0000, dst_idx_q};
        OFS_OPD_DEST: rd_val = {16'h0000, opd_dest_q};
        OFS_OPD_SRC:  rd_val = {16'h0000, opd_src_q};
        OFS_STATUS:   rd_val = {26'h0000000, rep_q, 1'b0, last_op_q};
        default:      rd_val = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // bus slave and execution next state
  always_comb
  begin
    state_d    = state_q;
    wait_d     = 1'b1;
    rdata_d    = rdata_q;
    flags_d    = flags_q;
    acc_d      = acc_q;
    ext_d      = ext_q;
    src_idx_d  = src_idx_q;
    dst_idx_d  = dst_idx_q;
    opd_dest_d = opd_dest_q;
    opd_src_d  = opd_src_q;
    rep_d      = rep_q;
    last_op_d  = last_op_q;
    mem_d      = mem_q;
    soft_d     = 1'b0;
    unique case (state_q)
      ST_IDLE:
      begin
        if (avs_read || avs_write)
        begin
          state_d = ST_ACK;
          wait_d  = 1'b0;
          rdata_d = rd_val;
        end
      end
      ST_ACK:
      begin
        state_d = ST_IDLE;
      end
    endcase
    if (fire_wr && avs_address[MEM_SEL_BIT])
      mem_d[avs_address[MEM_AW+1:2]] = avs_writedata[7:0];
    else if (fire_wr)
    begin
      unique case (avs_address)
        OFS_FLAGS:    flags_d    = avs_writedata[15:0];
        OFS_ACC:      acc_d      = avs_writedata[15:0];
        OFS_EXT:      ext_d      = avs_writedata[15:0];
        OFS_SRC_IDX:  src_idx_d  = avs_writedata[15:0];
        OFS_DST_IDX:  dst_idx_d  = avs_writedata[15:0];
        OFS_OPD_DEST: opd_dest_d = avs_writedata[15:0];
        OFS_OPD_SRC:  opd_src_d  = avs_writedata[15:0];
        default:      ;
      endcase
    end
    if (cmd_fire)
    begin
      last_op_d = cmd_op;
      unique case (cmd_op)
        OP_CLR_IE:    flags_d[FL_IE] = 1'b0;
        OP_TOG_CARRY: flags_d[FL_CARRY] = ~flags_q[FL_CARRY];
        OP_COMPARE, OP_STR_COMPARE:
        begin
          flags_d[FL_CARRY] = alu.carry;
          flags_d[FL_AUX]   = alu.aux;
          flags_d[FL_OVF]   = alu.ovf;
          flags_d[FL_SIGN]  = alu.sign;
          flags_d[FL_ZERO]  = alu.zero;
          flags_d[FL_PAR]   = alu.par;
          if (cmd_op == OP_STR_COMPARE)
          begin
            // repeat form runs one element per command; looping is the caller's
            rep_d = cmd_rep;
            if (flags_q[FL_DIR])
            begin
              src_idx_d = src_idx_q - step;
              dst_idx_d = dst_idx_q - step;
            end
            else
            begin
              src_idx_d = src_idx_q + step;
              dst_idx_d = dst_idx_q + step;
            end
          end
        end
        OP_SIGN_EXT: ext_d = (acc_q < SIGN_LIMIT) ? EXT_POS : EXT_NEG;
        OP_DEC_ADJ_ADD, OP_DEC_ADJ_SUB:
        begin
          // overflow is left as it was rather than invented
          acc_d[7:0]         = adj2;
          flags_d[FL_AUX]    = aux1;
          flags_d[FL_CARRY]  = cry1;
          flags_d[FL_SIGN]   = adj2[7];
          flags_d[FL_ZERO]   = (adj2 == 8'h00);
          flags_d[FL_PAR]    = ~^adj2;
        end
        OP_SOFT_INT: soft_d = 1'b1;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_q    <= ST_IDLE;
      wait_q     <= 1'b1;
      rdata_q    <= 32'h0000_0000;
      flags_q    <= FLAGS_RST;
      acc_q      <= 16'h0000;
      ext_q      <= 16'h0000;
      src_idx_q  <= 16'h0000;
      dst_idx_q  <= 16'h0000;
      opd_dest_q <= 16'h0000;
      opd_src_q  <= 16'h0000;
      rep_q      <= 1'b0;
      last_op_q  <= OP_NOP;
      soft_q     <= 1'b0;
      for (int i = 0; i < MEM_DEPTH; i++)
        mem_q[i] <= 8'h00;
    end
    else
    begin
      state_q    <= state_d;
      wait_q     <= wait_d;
      rdata_q    <= rdata_d;
      flags_q    <= flags_d;
      acc_q      <= acc_d;
      ext_q      <= ext_d;
      src_idx_q  <= src_idx_d;
      dst_idx_q  <= dst_idx_d;
      opd_dest_q <= opd_dest_d;
      opd_src_q  <= opd_src_d;
      rep_q      <= rep_d;
      last_op_q  <= last_op_d;
      soft_q     <= soft_d;
      mem_q      <= mem_d;
    end
  end

  // ==========================================================
  // interrupt recognition; nmi is edge triggered, maskable is a level
  always_comb
  begin
    mask_take_d = irq_s2_q && flags_q[FL_IE];
    nmi_take_d  = nmi_s2_q && !nmi_s3_q;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      irq_s1_q    <= 1'b0;
      irq_s2_q    <= 1'b0;
      nmi_s1_q    <= 1'b0;
      nmi_s2_q    <= 1'b0;
      nmi_s3_q    <= 1'b0;
      mask_take_q <= 1'b0;
      nmi_take_q  <= 1'b0;
    end
    else
    begin
      irq_s1_q    <= maskable_request_line;
      irq_s2_q    <= irq_s1_q;
      nmi_s1_q    <= nmi_line;
      nmi_s2_q    <= nmi_s1_q;
      nmi_s3_q    <= nmi_s2_q;
      mask_take_q <= mask_take_d;
      nmi_take_q  <= nmi_take_d;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  property p_clr_ie;
    cmd_fire && cmd_op == OP_CLR_IE |=>
      !flags_q[FL_IE] && flags_q[8:0] == $past(flags_q[8:0])
      && flags_q[15:10] == $past(flags_q[15:10]);
  endproperty
  a_clr_ie: assert property (p_clr_ie) else $error("ie not cleared alone");

  property p_mask;
    !flags_q[FL_IE] |=> !maskable_taken;
  endproperty
  a_mask: assert property (p_mask) else $error("masked request taken");

  property p_nmi;
    $rose(nmi_s2_q) && !flags_q[FL_IE] |=> nmi_taken ##1 !nmi_taken;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi not one pulse");

  property p_tog_carry;
    cmd_fire && cmd_op == OP_TOG_CARRY |=>
      flags_q[FL_CARRY] != $past(flags_q[FL_CARRY]) && flags_q[15:1] == $past(flags_q[15:1]);
  endproperty
  a_tog_carry: assert property (p_tog_carry) else $error("carry toggle wrong");

  property p_compare_keep;
    cmd_fire && cmd_op == OP_COMPARE |=>
      opd_dest_q == $past(opd_dest_q) && opd_src_q == $past(opd_src_q) && acc_q == $past(acc_q);
  endproperty
  a_compare_keep: assert property (p_compare_keep) else $error("compare altered operand");

  property p_compare_gt;
    cmd_fire && cmd_op == OP_COMPARE && cmd_word && $signed(opd_dest_q) > $signed(opd_src_q)
      |=> !flags_q[FL_ZERO] && flags_q[FL_SIGN] == flags_q[FL_OVF];
  endproperty
  a_compare_gt: assert property (p_compare_gt) else $error("greater not reflected");

  property p_str_inc;
    cmd_fire && cmd_op == OP_STR_COMPARE && !flags_q[FL_DIR] && !cmd_word
      |=> dst_idx_q == $past(dst_idx_q) + STEP_BYTE && src_idx_q == $past(src_idx_q) + STEP_BYTE;
  endproperty
  a_str_inc: assert property (p_str_inc) else $error("byte step up wrong");

  property p_str_dec;
    cmd_fire && cmd_op == OP_STR_COMPARE && flags_q[FL_DIR] && cmd_word
      |=> src_idx_q == $past(src_idx_q) - STEP_WORD && dst_idx_q == $past(dst_idx_q) - STEP_WORD;
  endproperty
  a_str_dec: assert property (p_str_dec) else $error("word step down wrong");

  property p_sign_ext;
    cmd_fire && cmd_op == OP_SIGN_EXT |=>
      ext_q == ($past(acc_q[15]) ? EXT_NEG : EXT_POS) && flags_q == $past(flags_q);
  endproperty
  a_sign_ext: assert property (p_sign_ext) else $error("sign extend wrong");

  property p_dec_add_aux;
    cmd_fire && cmd_op == OP_DEC_ADJ_ADD && (acc_q[7:0] & BCD_NIB_MASK) > BCD_NIB_MAX
      |=> flags_q[FL_AUX] && flags_q[FL_DIR] == $past(flags_q[FL_DIR]);
  endproperty
  a_dec_add_aux: assert property (p_dec_add_aux) else $error("add adjust aux wrong");

  property p_dec_sub_carry;
    cmd_fire && cmd_op == OP_DEC_ADJ_SUB && flags_q[FL_CARRY] |=>
      flags_q[FL_CARRY] && flags_q[FL_IE] == $past(flags_q[FL_IE]);
  endproperty
  a_dec_sub_carry: assert property (p_dec_sub_carry) else $error("sub adjust carry lost");

  property p_rep;
    cmd_fire && cmd_op == OP_STR_COMPARE |=> rep_q == $past(cmd_rep);
  endproperty
  a_rep: assert property (p_rep) else $error("repeat form not held");
endmodule

// File: bench/test_compare_adjust_flag_ops.sv
/*
 * test_compare_adjust_flag_ops: self-checking bench for cafo_exec.
 * Assumes cafo_exec answers every Avalon request after a fixed wait.
 */
`timescale 1ns/1ps
module test_compare_adjust_flag_ops
  import cafo_pkg::*;
;
  typedef struct {
    logic [31:0] v;
    logic [31:0] m;
    string       n;
  } cafo_exp_t;

  logic              ref_clk               = 1'b0;
  logic              sys_rst               = 1'b1;
  logic [ADDR_W-1:0] avs_address           = 7'h00;
  logic              avs_read              = 1'b0;
  logic              avs_write             = 1'b0;
  logic [DATA_W-1:0] avs_writedata         = 32'h0;
  logic [DATA_W-1:0] avs_readdata;
  logic              avs_waitrequest;
  logic              maskable_request_line = 1'b0;
  logic              nmi_line              = 1'b0;
  logic              maskable_taken;
  logic              nmi_taken;
  logic              soft_taken;
  cafo_exp_t         exp_q [$];
  cafo_exp_t         got;
  int                miscompares           = 0;
  int                checked               = 0;
  int                cyc                   = 0;
  int                mt_n                  = 0;
  int                nmi_n                 = 0;
  int                soft_n                = 0;

  always #4 ref_clk = ~ref_clk;

  cafo_exec u_dut (
    .ref_clk               (ref_clk),
    .sys_rst               (sys_rst),
    .avs_address           (avs_address),
    .avs_read              (avs_read),
    .avs_write             (avs_write),
    .avs_writedata         (avs_writedata),
    .avs_readdata          (avs_readdata),
    .avs_waitrequest       (avs_waitrequest),
    .maskable_request_line (maskable_request_line),
    .nmi_line              (nmi_line),
    .maskable_taken        (maskable_taken),
    .nmi_taken             (nmi_taken),
    .soft_taken            (soft_taken)
  );

  // ==========================================================
  // reporting
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wrap_up;
    if (miscompares == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================================
  // bus master; called just after a rising edge
  task automatic bus(input logic rd, input logic [6:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_read      <= rd;
    avs_write     <= ~rd;
    avs_writedata <= d;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    // one idle edge so the next request never lands in the same step
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    bus(1'b0, a, {16'h0, d});
  endtask

  task automatic rd(input logic [6:0] a, input logic [31:0] e, input logic [31:0] m,
                    input string n);
    exp_q.push_back('{e, m, n});
    bus(1'b1, a, 32'h0);
  endtask

  task automatic cmd(input logic [3:0] op, input logic w = 1'b0, input logic r = 1'b0);
    bus(1'b0, OFS_CMD, {26'h0, r, w, op});
  endtask

  // ==========================================================
  // reference arithmetic
  function automatic logic [15:0] subf(input logic [15:0] f, a, b, input logic w);
    logic [16:0] d;
    logic        s;
    d = w ? {1'b0, a} - {1'b0, b} : {9'h000, a[7:0]} - {9'h000, b[7:0]};
    s = w ? d[15] : d[7];
    f[FL_CARRY] = w ? d[16] : d[8];
    f[FL_AUX]   = a[3:0] < b[3:0];
    f[FL_OVF]   = w ? (a[15] ^ b[15]) & (s ^ a[15]) : (a[7] ^ b[7]) & (s ^ a[7]);
    f[FL_SIGN]  = s;
    f[FL_ZERO]  = w ? d[15:0] == 16'h0 : d[7:0] == 8'h00;
    f[FL_PAR]   = ~^d[7:0];
    return f;
  endfunction

  function automatic logic [15:0] dadj(input logic [15:0] f, input logic [7:0] al,
                                       input logic sb, output logic [7:0] r);
    r = al;
    if ((r & 8'h0f) > 8'h09 || f[FL_AUX])
    begin
      r = sb ? r - 8'h06 : r + 8'h06;
      f[FL_AUX] = 1'b1;
    end
    // second test sees the byte after the first step
    if (r > 8'h9f || f[FL_CARRY])
    begin
      r = sb ? r - 8'h60 : r + 8'h60;
      f[FL_CARRY] = 1'b1;
    end
    f[FL_SIGN] = r[7];
    f[FL_ZERO] = r == 8'h00;
    f[FL_PAR]  = ~^r;
    return f;
  endfunction

  // ==========================================================
  // result watcher, pulse counters and timeout
  always @(posedge ref_clk)
  begin
    cyc++;
    if (maskable_taken === 1'b1)
      mt_n++;
    if (nmi_taken === 1'b1)
      nmi_n++;
    if (soft_taken === 1'b1)
      soft_n++;
    if (avs_waitrequest === 1'b0 && avs_read === 1'b1 && exp_q.size() > 0)
    begin
      got = exp_q.pop_front();
      check(got.n, avs_readdata & got.m, got.v & got.m);
    end
    if (cyc == 20000)
    begin
      miscompares++;
      wrap_up();
    end
  end

  // ==========================================================
  // scenarios
  initial
  begin
    logic [15:0] a, b, f, si, dp, e;
    logic [7:0]  r;
    logic [7:0]  m [16];
    logic        w;
    int          t;
    void'($urandom(32'hbbd81173));
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    wr(7'h24, 16'h5a5a);
    rd(7'h24, 32'h0, 32'hffffffff, "unmapped");
    f = 16'h0ed5;
    wr(OFS_FLAGS, f);
    cmd(4'h1);
    rd(OFS_FLAGS, 32'h0cd5, 32'h0ed5, "clr_ie_flags");
    f = 16'($urandom) & 16'h0ed5;
    wr(OFS_FLAGS, f);
    repeat (2)
    begin
      cmd(4'h2);
      f[FL_CARRY] = ~f[FL_CARRY];
      rd(OFS_FLAGS, {16'h0, f}, 32'h0ed5, "tog_carry_flags");
    end
    for (t = 0; t < 12; t++)
    begin
      a = 16'($urandom);
      b = (t < 2) ? a : 16'($urandom);
      w = t[0];
      f = 16'($urandom) & 16'h0ed5;
      wr(OFS_FLAGS, f);
      wr(OFS_OPD_DEST, a);
      wr(OFS_OPD_SRC, b);
      cmd(4'h3, w);
      rd(OFS_FLAGS, {16'h0, subf(f, a, b, w)}, 32'h0ed5, "compare_flags");
      rd(OFS_OPD_DEST, {16'h0, a}, 32'hffff, "compare_dest");
      rd(OFS_OPD_SRC, {16'h0, b}, 32'hffff, "compare_src");
    end
    for (t = 0; t < 16; t++)
    begin
      m[t] = 8'($urandom);
      wr(7'h40 + 7'(4 * t), {8'h00, m[t]});
    end
    for (t = 0; t < 8; t++)
    begin
      si = 16'(4 + t);
      dp = 16'(11 - t);
      w  = t[1];
      a  = {w ? m[dp[3:0] + 4'h1] : 8'h00, m[dp[3:0]]};
      b  = {w ? m[si[3:0] + 4'h1] : 8'h00, m[si[3:0]]};
      f  = 16'($urandom) & 16'h0ed5;
      f[FL_DIR] = t[0];
      e  = w ? 16'h0002 : 16'h0001;
      wr(OFS_FLAGS, f);
      wr(OFS_SRC_IDX, si);
      wr(OFS_DST_IDX, dp);
      cmd(4'h4, w, t[2]);
      rd(OFS_FLAGS, {16'h0, subf(f, a, b, w)}, 32'h0ed5, "str_flags");
      rd(OFS_SRC_IDX, {16'h0, t[0] ? si - e : si + e}, 32'hffff, "src_idx");
      rd(OFS_DST_IDX, {16'h0, t[0] ? dp - e : dp + e}, 32'hffff, "dst_idx");
      rd(OFS_STATUS, {26'h0, t[2], 5'h04}, 32'h2f, "str_status");
    end
    for (t = 0; t < 16; t++)
      rd(7'h40 + 7'(4 * t), {24'h0, m[t]}, 32'hff, "mem_kept");
    for (t = 0; t < 6; t++)
    begin
      a = (t < 2) ? (t[0] ? 16'h8000 : 16'h7fff) : 16'($urandom);
      f = 16'($urandom) & 16'h0ed5;
      wr(OFS_EXT, 16'($urandom));
      wr(OFS_ACC, a);
      wr(OFS_FLAGS, f);
      cmd(4'h5);
      rd(OFS_EXT, {16'h0, a < 16'h8000 ? 16'h0000 : 16'hffff}, 32'hffff, "ext_word");
      rd(OFS_FLAGS, {16'h0, f}, 32'h0ed5, "ext_flags");
    end
    for (t = 0; t < 24; t++)
    begin
      a = 16'($urandom);
      f = 16'($urandom) & 16'h0ed5;
      e = dadj(f, a[7:0], t[0], r);
      wr(OFS_FLAGS, f);
      wr(OFS_ACC, a);
      cmd(t[0] ? 4'h7 : 4'h6);
      rd(OFS_ACC, {16'h0, a[15:8], r}, 32'hffff, "adj_acc");
      rd(OFS_FLAGS, {16'h0, e}, 32'h06d5, "adj_flags");
    end
    // idle and undefined codes only record the last op
    cmd(4'h0);
    rd(OFS_STATUS, 32'h0, 32'h0f, "nop_status");
    cmd(4'hf);
    rd(OFS_STATUS, 32'hf, 32'h0f, "odd_status");
    // two sync stages plus the output flop
    wr(OFS_FLAGS, 16'h0200);
    maskable_request_line <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check("mask_on", {31'h0, maskable_taken}, 32'h1);
    cmd(4'h1);
    repeat (2) @(posedge ref_clk);
    mt_n = 0;
    repeat (16) @(posedge ref_clk);
    check("mask_off", 32'(mt_n), 32'h0);
    t = nmi_n;
    nmi_line <= 1'b1;
    repeat (6) @(posedge ref_clk);
    nmi_line <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check("nmi", 32'(nmi_n - t), 32'h1);
    t = soft_n;
    cmd(4'h8);
    repeat (4) @(posedge ref_clk);
    check("soft", 32'(soft_n - t), 32'h1);
    maskable_request_line <= 1'b0;
    wrap_up();
  end
endmodule
